// ### gpb_regs.vh
// register map, field positions and reset values of the port b block
`ifndef GPB_REGS_VH
`define GPB_REGS_VH

// byte offsets on the register bus
`define GPB_ADDR_PINS      5'h00
`define GPB_ADDR_LATCH     5'h04
`define GPB_ADDR_DIR       5'h08
`define GPB_ADDR_INTMAIN   5'h0c
`define GPB_ADDR_INTCTL2   5'h10
`define GPB_ADDR_ANALOG    5'h14

// field positions
`define GPB_BIT_CHANGE_FLAG  0
`define GPB_BIT_PULLUP_N     7

// reset values
`define GPB_RST_DIR      8'hff
`define GPB_RST_LATCH    8'h00
`define GPB_RST_INTCTL2  8'h80
`define GPB_ANALOG_ALL   5'h1f

// axi response codes
`define GPB_RESP_OKAY    2'b00
`define GPB_RESP_SLVERR  2'b10

`endif

// ### gpb_port.v
// port b gpio block with change detection, pull-ups and pin sharing
`default_nettype none
`include "gpb_regs.vh"

// How it works
// - eight bidirectional pins, each with direction, latch and readable level
// - direction 1 tristates the driver; 0 drives the latch bit
// - latch register is mapped and reads back latch contents, not pins
// - one active-low control bit, bit 7 of control 2, enables all pull-ups
// - pull-up is off on any pin configured as output
// - all pull-ups are off after power-on reset
// - reset default: lower five pins analog reading 0, upper three digital
// - a configuration bit can make the lower five pins digital at reset
// - analog-default bit set gives analog lower pins, cleared gives digital
// - change detection only on upper four pins, outputs excluded
// - input pins compared with read snapshot, mismatches ORed into flag bit 0
// - a persisting mismatch keeps setting the flag against software clears
// - port read or write updates snapshot; register move reads do not
// - change flag drives a wake request out of sleep or idle
// - capture/compare channel on pin 3 when pin-map bit is 0
// - analog selection leaves output path, disables digital input buffer
// - external interrupts 0..2 taken from pins 0..2 when inputs
// - pin 0 as input feeds pwm fault input when enabled by software
// - low-voltage programming makes pin 5 entry input, other functions off
// - programming active: pin 6 serial clock, pin 7 bidirectional data
// - all other functions of pins 6 and 7 off while programming
module gpb_port (
    input  wire        clk_i,
    input  wire        reset_i,
    // axi4-lite slave
    input  wire [4:0]  s_axi_awaddr_i,
    input  wire        s_axi_awvalid_i,
    output reg         s_axi_awready_o,
    input  wire [31:0] s_axi_wdata_i,
    input  wire [3:0]  s_axi_wstrb_i,
    input  wire        s_axi_wvalid_i,
    output reg         s_axi_wready_o,
    output reg  [1:0]  s_axi_bresp_o,
    output reg         s_axi_bvalid_o,
    input  wire        s_axi_bready_i,
    input  wire [4:0]  s_axi_araddr_i,
    input  wire        s_axi_arvalid_i,
    output reg         s_axi_arready_o,
    output reg  [31:0] s_axi_rdata_o,
    output reg  [1:0]  s_axi_rresp_o,
    output reg         s_axi_rvalid_o,
    input  wire        s_axi_rready_i,
    input  wire        move_read_i,
    // configuration straps
    input  wire        analog_default_cfg_i,
    input  wire        capcomp2_pin_map_cfg_i,
    input  wire        low_voltage_prog_cfg_i,
    input  wire        prog_active_i,
    // pins
    input  wire [7:0]  pin_in_i,
    output reg  [7:0]  pin_out_o,
    output reg  [7:0]  pin_oe_n_o,
    output reg  [7:0]  pullup_on_o,
    // peripheral sharing
    input  wire        capture_compare_2_out_i,
    input  wire        pwm_fault_en_i,
    input  wire        prog_data_out_i,
    input  wire        prog_data_oe_i,
    output reg         capture_compare_2_capture_o,
    output reg  [2:0]  ext_irq_o,
    output reg         pwm_fault_input_o,
    output reg         prog_mode_entry_o,
    output reg         prog_serial_clock_o,
    output reg         prog_serial_data_o,
    output reg         port_change_flag_o,
    output reg         wake_o
);

    reg  [7:0] port_b_direction_reg;
    reg  [7:0] port_b_output_latch_reg;
    reg  [7:0] interrupt_control_2_reg;
    reg  [4:0] analog_sel_reg;
    reg        port_change_flag_reg;
    reg  [3:0] snapshot_reg;
    reg        strap_done_reg;
    reg  [4:0] aw_addr_reg;
    reg        aw_have_reg;
    reg [31:0] w_data_reg;
    reg  [3:0] w_strb_reg;
    reg        w_have_reg;

    wire       pullup_enable_n = interrupt_control_2_reg[`GPB_BIT_PULLUP_N];
    wire       pin3_alt        = ~capcomp2_pin_map_cfg_i;
    wire       pin5_prog       = low_voltage_prog_cfg_i;
    wire [7:0] pin_is_output;
    wire [7:0] pin_digital_in;
    wire [3:0] change_mismatch;
    wire       wr_go;
    wire       rd_go;
    wire       wr_pins;
    wire       rd_pins;
    wire       clear_flag;
    wire [7:0] pin_taken;
    // next values of the registered pin outputs
    reg  [7:0] pin_out_next;
    reg  [7:0] pin_oe_n_next;
    reg  [7:0] pullup_next;

    // register map, one aligned word each, only byte lane 0 is used
    //   0x00  pin levels; a write lands in the output latch
    //   0x04  output latch, read back as written
    //   0x08  direction, 1 = input, 0 = driven
    //   0x0c  main control, bit 0 change flag, write 0 to clear
    //   0x10  control 2, bit 7 pull-up enable, active low
    //   0x14  analog select for the lower five pins
    //   other offsets answer with a slave error and read as zero
    // control 2 keeps its other bits as written, they drive nothing here
    // the flag bit is read only apart from the clear; writing 1 does nothing
    // a pin in analog mode still drives when its direction says so
    // limitation: writes without wstrb[0] are answered but change nothing except the snapshot on a pin-word write

    // register address match, used for read and write decode
    function addr_hit;
        input [4:0] a;
        input [4:0] off;
        begin
            // word match; the two byte-select bits are ignored
            addr_hit = (a[4:2] == off[4:2]);
        end
    endfunction

    // pin ownership: programming functions take pins 5 to 7 from the port
    assign pin_taken[4:0] = 5'h00;
    // entry pin leaves the port under low-voltage programming
    assign pin_taken[5]   = pin5_prog;
    // clock and data pins leave the port while programming
    assign pin_taken[6]   = prog_active_i;
    assign pin_taken[7]   = prog_active_i;

    // per-pin direction and input path
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_pin
            assign pin_is_output[g] = ~port_b_direction_reg[g];
            if (g < 5) begin : g_ana
                assign pin_digital_in[g] = analog_sel_reg[g] ? 1'b0 : pin_in_i[g];
            end else begin : g_dig
                assign pin_digital_in[g] = pin_in_i[g];
            end
        end
        for (g = 0; g < 4; g = g + 1) begin : g_chg
            // pins held by programming are left out as well
            assign change_mismatch[g] = ~pin_is_output[g+4] & ~pin_taken[g+4] &
                                        (pin_digital_in[g+4] != snapshot_reg[g]);
        end
    endgenerate

    assign wr_go   = aw_have_reg & w_have_reg & ~s_axi_bvalid_o;
    assign rd_go   = s_axi_arvalid_i & s_axi_arready_o;
    // move form excluded from snapshot update
    assign wr_pins    = wr_go & addr_hit(aw_addr_reg, `GPB_ADDR_PINS);
    assign rd_pins    = rd_go & addr_hit(s_axi_araddr_i, `GPB_ADDR_PINS) & ~move_read_i;
    // software clears the flag by writing a zero to bit 0
    assign clear_flag = wr_go & addr_hit(aw_addr_reg, `GPB_ADDR_INTMAIN) & w_strb_reg[0] &
                        ~w_data_reg[`GPB_BIT_CHANGE_FLAG];

    // timing: awready and wready fall for the cycle after a transfer and
    // stay low while a write is held or its response waits, so a second
    // write cannot overtake the first; bvalid follows one cycle after both
    // halves are held; rvalid follows one cycle after the read address is
    // taken and arready rises again one cycle after rvalid drops
    // a write to the pin word also lands in the latch and refreshes the
    // snapshot; a pin read through the move form leaves the snapshot alone

    // axi write channel capture and response
    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            aw_have_reg     <= 1'b0;
            w_have_reg      <= 1'b0;
            aw_addr_reg     <= 5'h00;
            w_data_reg      <= 32'h0000_0000;
            w_strb_reg      <= 4'h0;
            s_axi_awready_o <= 1'b0;
            s_axi_wready_o  <= 1'b0;
            s_axi_bvalid_o  <= 1'b0;
            s_axi_bresp_o   <= `GPB_RESP_OKAY;
        end else begin
            // accept each half once, never while a response waits
            s_axi_awready_o <= ~aw_have_reg & ~(s_axi_awvalid_i & s_axi_awready_o) & ~s_axi_bvalid_o;
            s_axi_wready_o  <= ~w_have_reg & ~(s_axi_wvalid_i & s_axi_wready_o) & ~s_axi_bvalid_o;
            // hold the address until the data has come too
            if (s_axi_awvalid_i & s_axi_awready_o) begin
                aw_have_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr_i;
            end
            // hold data and strobes until the address has come too
            if (s_axi_wvalid_i & s_axi_wready_o) begin
                w_have_reg <= 1'b1;
                w_data_reg <= s_axi_wdata_i;
                w_strb_reg <= s_axi_wstrb_i;
            end
            // both halves held: answer, unmapped words get a slave error
            if (wr_go) begin
                aw_have_reg    <= 1'b0;
                w_have_reg     <= 1'b0;
                s_axi_bvalid_o <= 1'b1;
                s_axi_bresp_o  <= (aw_addr_reg[4:2] <= 3'd5) ? `GPB_RESP_OKAY : `GPB_RESP_SLVERR;
            end else if (s_axi_bvalid_o & s_axi_bready_i) begin
                s_axi_bvalid_o <= 1'b0;
            end
        end
    end

    // axi read channel
    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o  <= 1'b0;
            s_axi_rdata_o   <= 32'h0000_0000;
            s_axi_rresp_o   <= `GPB_RESP_OKAY;
        end else begin
            // one read at a time: no new address while data waits
            s_axi_arready_o <= ~s_axi_rvalid_o & ~rd_go;
            if (rd_go) begin
                s_axi_rvalid_o <= 1'b1;
                s_axi_rresp_o  <= `GPB_RESP_OKAY;
                case (s_axi_araddr_i[4:2])
                    // pin level for inputs and outputs
                    3'd0: s_axi_rdata_o <= {24'h000000, pin_digital_in};
                    3'd1: s_axi_rdata_o <= {24'h000000, port_b_output_latch_reg};
                    // direction, control 2 and analog select read as stored
                    3'd2: s_axi_rdata_o <= {24'h000000, port_b_direction_reg};
                    // change flag alone in bit 0
                    3'd3: s_axi_rdata_o <= {31'h00000000, port_change_flag_reg};
                    3'd4: s_axi_rdata_o <= {24'h000000, interrupt_control_2_reg};
                    3'd5: s_axi_rdata_o <= {27'h0000000, analog_sel_reg};
                    default: begin
                        s_axi_rdata_o <= 32'h0000_0000;
                        s_axi_rresp_o <= `GPB_RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rvalid_o & s_axi_rready_i) begin
                s_axi_rvalid_o <= 1'b0;
            end
        end
    end

    // software-written registers
    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            port_b_direction_reg    <= `GPB_RST_DIR;
            port_b_output_latch_reg <= `GPB_RST_LATCH;
            interrupt_control_2_reg <= `GPB_RST_INTCTL2;
            analog_sel_reg          <= `GPB_ANALOG_ALL;
            strap_done_reg          <= 1'b0;
        end else begin
            // first edge after reset loads the strap, writes wait until then;
            // changing the strap later has no effect until the next reset
            strap_done_reg <= 1'b1;
            if (!strap_done_reg) begin
                analog_sel_reg <= analog_default_cfg_i ? `GPB_ANALOG_ALL : 5'h00;
            end else if (wr_go && w_strb_reg[0]) begin
                case (aw_addr_reg[4:2])
                    // port write lands in the latch
                    3'd0: port_b_output_latch_reg <= w_data_reg[7:0];
                    3'd1: port_b_output_latch_reg <= w_data_reg[7:0];
                    3'd2: port_b_direction_reg    <= w_data_reg[7:0];
                    3'd4: interrupt_control_2_reg <= w_data_reg[7:0];
                    // analog select turns digital input buffers off
                    3'd5: analog_sel_reg          <= w_data_reg[4:0];
                    default: port_b_direction_reg <= port_b_direction_reg;
                endcase
            end
        end
    end

    // snapshot and change flag
    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            snapshot_reg         <= 4'h0;
            port_change_flag_reg <= 1'b0;
        end else begin
            if (rd_pins | wr_pins) begin
                snapshot_reg <= pin_digital_in[7:4];
            end
            // the snapshot holds the upper pins as last seen by a port access;
            // while a listening pin differs the flag is forced high each cycle,
            // so the handler must touch the port before clearing the flag
            // set wins over clear
            if (|change_mismatch) begin
                port_change_flag_reg <= 1'b1;
            end else if (clear_flag) begin
                port_change_flag_reg <= 1'b0;
            end
        end
    end

    // next pin drive, pull-up and owner overrides
    always @* begin
        // defaults: the port owns every pin, latch onto driven pins
        pin_out_next  = port_b_output_latch_reg;
        pin_oe_n_next = port_b_direction_reg;
        pullup_next   = {8{~pullup_enable_n}} & ~pin_is_output;
        // compare output replaces the latch on pin 3
        if (pin3_alt && pin_is_output[3]) begin
            pin_out_next[3] = capture_compare_2_out_i;
        end
        if (pin5_prog) begin
            pin_oe_n_next[5] = 1'b1;
            pullup_next[5]   = 1'b0;
        end
        // clock pin listens, data pin follows the programmer
        if (prog_active_i) begin
            pin_oe_n_next[6] = 1'b1;
            pullup_next[6]   = 1'b0;
            pin_out_next[7]  = prog_data_out_i;
            pin_oe_n_next[7] = ~prog_data_oe_i;
            pullup_next[7]   = 1'b0;
        end
    end

    // pin drive, pull-ups and shared functions
    // shared-function inputs read the raw pin, not the analog-gated level
    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            pin_out_o           <= 8'h00;
            pin_oe_n_o          <= 8'hff;
            pullup_on_o         <= 8'h00;
            capture_compare_2_capture_o      <= 1'b0;
            ext_irq_o           <= 3'b000;
            pwm_fault_input_o   <= 1'b0;
            prog_mode_entry_o   <= 1'b0;
            prog_serial_clock_o <= 1'b0;
            prog_serial_data_o  <= 1'b0;
            port_change_flag_o  <= 1'b0;
            wake_o              <= 1'b0;
        end else begin
            // registered copies of the next pin state
            pin_out_o   <= pin_out_next;
            pin_oe_n_o  <= pin_oe_n_next;
            pullup_on_o <= pullup_next;
            // capture input from pin 3 while it listens
            capture_compare_2_capture_o <= pin3_alt & ~pin_is_output[3] & pin_in_i[3];
            ext_irq_o <= pin_in_i[2:0] & ~pin_is_output[2:0];
            pwm_fault_input_o <= pwm_fault_en_i & ~pin_is_output[0] & pin_in_i[0];
            prog_mode_entry_o <= pin5_prog & pin_in_i[5];
            // programming takes pins 6 and 7
            prog_serial_clock_o <= prog_active_i & pin_in_i[6];
            prog_serial_data_o  <= prog_active_i & pin_in_i[7];
            port_change_flag_o <= port_change_flag_reg;
            // wake from sleep and idle; a level, the power control
            // decides which mode it ends
            wake_o <= port_change_flag_reg;
        end
    end

endmodule // gpb_port
`default_nettype wire

// ### gpb_port_assertions.sv
// assertion checker for the port b block
`default_nettype none
module gpb_port_assertions (
    input wire logic       clk_i,
    input wire logic       reset_i,
    input wire logic       s_axi_awvalid_i,
    input wire logic       s_axi_bvalid_o,
    input wire logic       capcomp2_pin_map_cfg_i,
    input wire logic       low_voltage_prog_cfg_i,
    input wire logic       prog_active_i,
    input wire logic       prog_data_out_i,
    input wire logic       prog_data_oe_i,
    input wire logic       capture_compare_2_out_i,
    input wire logic [7:0] pin_in_i,
    input wire logic [7:0] pin_out_o,
    input wire logic [7:0] pin_oe_n_o,
    input wire logic [7:0] pullup_on_o,
    input wire logic       prog_mode_entry_o,
    input wire logic       prog_serial_clock_o,
    input wire logic       port_change_flag_o,
    input wire logic       wake_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    // compare channel owns pin 3 while it drives
    sequence s_ccp_drive; !capcomp2_pin_map_cfg_i ##1 !pin_oe_n_o[3]; endsequence
    property p_capture_compare_2; s_ccp_drive |-> pin_out_o[3] == $past(capture_compare_2_out_i); endproperty
    a_capture_compare_2: assert property (p_capture_compare_2) else $error("pin 3 not compare output");
    property p_pullup_out; (pullup_on_o & ~pin_oe_n_o) == 8'h00; endproperty
    a_pullup_out: assert property (p_pullup_out) else $error("pull-up on driven pin");
    property p_reset; $fell(reset_i) |-> pin_oe_n_o == 8'hff && pullup_on_o == 8'h00; endproperty
    a_reset: assert property (p_reset) else $error("reset state wrong");
    property p_wake; port_change_flag_o |-> ##[0:1] wake_o; endproperty
    a_wake: assert property (p_wake) else $error("no wake on change");
    // only a write may remove the flag
    property p_hold; port_change_flag_o && !s_axi_awvalid_i && !$past(s_axi_awvalid_i)
        && !s_axi_bvalid_o |=> port_change_flag_o; endproperty
    a_hold: assert property (p_hold) else $error("flag lost without write");
    property p_pclk; prog_active_i |=> prog_serial_clock_o == $past(pin_in_i[6]); endproperty
    a_pclk: assert property (p_pclk) else $error("serial clock wrong");
    property p_pdat; prog_active_i && prog_data_oe_i |=> !pin_oe_n_o[7]
        && pin_out_o[7] == $past(prog_data_out_i); endproperty
    a_pdat: assert property (p_pdat) else $error("serial data not driven");
    property p_entry; low_voltage_prog_cfg_i |=> prog_mode_entry_o == $past(pin_in_i[5]); endproperty
    a_entry: assert property (p_entry) else $error("mode entry wrong");
endmodule // gpb_port_assertions
bind gpb_port gpb_port_assertions u_chk (.*);
`default_nettype wire

// ### gpb_pin_model.sv
// pad and board model resolving the port b pin levels
`default_nettype none
module gpb_pin_model (
    input  wire logic       clk_i,
    input  wire logic [7:0] pin_out_i,
    input  wire logic [7:0] pin_oe_n_i,
    input  wire logic [7:0] pullup_on_i,
    input  wire logic [7:0] ext_val_i,
    input  wire logic [7:0] ext_en_i,
    output wire logic [7:0] pin_level_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] last_reg;
    // floating pins drift away from their last level
    always_ff @(posedge clk_i) last_reg <= pin_level_o;
    // driver first, then board, then pull-up
    assign pin_level_o = (~pin_oe_n_i & pin_out_i) | (pin_oe_n_i & ext_en_i & ext_val_i)
                       | (pin_oe_n_i & ~ext_en_i & (pullup_on_i | ~last_reg));
endmodule // gpb_pin_model
`default_nettype wire

// ### tb_gpb_port.sv
// self-checking bench for the port b block
`default_nettype none
`include "gpb_regs.vh"
module tb_gpb_port;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [4:0] CTL2 = 5'h10, ANA = 5'h14, PINS = 5'h00, LAT = 5'h04, DIR = 5'h08, IMAIN = 5'h0c;
    logic clk_i = '0, reset_i = '1, s_axi_awvalid_i = '0, s_axi_wvalid_i = '0, s_axi_bready_i = '0;
    logic s_axi_arvalid_i = '0, s_axi_rready_i = '0, move_read_i = '0, analog_default_cfg_i = '1;
    logic capcomp2_pin_map_cfg_i = '1, low_voltage_prog_cfg_i = '0, prog_active_i = '0, capture_compare_2_out_i = '0;
    logic pwm_fault_en_i = '0, prog_data_out_i = '0, prog_data_oe_i = '0;
    logic [4:0] s_axi_awaddr_i = '0, s_axi_araddr_i = '0;
    logic [31:0] s_axi_wdata_i = '0, rd_data;
    logic [3:0] s_axi_wstrb_i = 4'h1;
    logic [7:0] ext_val = '0, r, d, k;
    logic [1:0] rd_resp, wr_resp;
    wire [7:0] pin_in_i, pin_out_o, pin_oe_n_o, pullup_on_o;
    wire [31:0] s_axi_rdata_o;
    wire [2:0] ext_irq_o;
    wire [1:0] s_axi_bresp_o, s_axi_rresp_o;
    wire s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o, capture_compare_2_capture_o;
    wire pwm_fault_input_o, prog_mode_entry_o, prog_serial_clock_o, prog_serial_data_o, port_change_flag_o, wake_o;
    int errors = 0, samples_checked = 0;
    int unsigned seed = 31651;
    gpb_port dut (.*);
    gpb_pin_model pins (.clk_i(clk_i), .pin_out_i(pin_out_o), .pin_oe_n_i(pin_oe_n_o), .pullup_on_i(pullup_on_o),
                        .ext_val_i(ext_val), .ext_en_i(8'hff), .pin_level_o(pin_in_i));
    initial forever #20 clk_i = ~clk_i;
    // xorshift source, low byte used
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    function automatic logic [7:0] f_pull(logic [7:0] dr, logic [7:0] c2);
        return c2[`GPB_BIT_PULLUP_N] ? 8'h00 : dr;
    endfunction
    function automatic logic [31:0] f_pins(logic [7:0] lv, logic [4:0] an);
        return {24'h0, lv & ~{3'h0, an}};
    endfunction
    task automatic complete_run();
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(string n, logic [31:0] seen, logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic wr(logic [4:0] a, logic [31:0] v);
        logic done;
        done = 0;
        @(posedge clk_i);
        s_axi_awaddr_i <= a;
        s_axi_wdata_i <= v;
        s_axi_awvalid_i <= 1;
        s_axi_wvalid_i <= 1;
        s_axi_bready_i <= 1;
        for (int n = 0; n < 40 && !done; n++) begin
            @(posedge clk_i);
            if (s_axi_awready_o) s_axi_awvalid_i <= 0;
            if (s_axi_wready_o) s_axi_wvalid_i <= 0;
            done = s_axi_bvalid_o;
            wr_resp = s_axi_bresp_o;
        end
        s_axi_bready_i <= 0;
        chk("write done", done, 1);
        if (!done) complete_run();
    endtask
    task automatic rd(logic [4:0] a);
        logic done;
        done = 0;
        @(posedge clk_i);
        s_axi_araddr_i <= a;
        s_axi_arvalid_i <= 1;
        s_axi_rready_i <= 1;
        for (int n = 0; n < 40 && !done; n++) begin
            @(posedge clk_i);
            if (s_axi_arready_o) s_axi_arvalid_i <= 0;
            done = s_axi_rvalid_o;
            rd_data = s_axi_rdata_o;
            rd_resp = s_axi_rresp_o;
        end
        s_axi_rready_i <= 0;
        chk("read done", done, 1);
        if (!done) complete_run();
    endtask
    task automatic wait_flag(logic e);
        for (int n = 0; n < 10 && port_change_flag_o !== e; n++) @(posedge clk_i);
        chk("change flag", port_change_flag_o, e);
        if (port_change_flag_o !== e) complete_run();
    endtask
    task automatic do_reset(logic cfg);
        analog_default_cfg_i <= cfg;
        reset_i <= 1;
        repeat (6) @(posedge clk_i);
        reset_i <= 0;
        repeat (2) @(posedge clk_i);
    endtask
    initial begin
        do_reset(1);
        chk("oe_n", pin_oe_n_o, 8'hff);
        chk("pullup", pullup_on_o, 8'h00);
        r = rnd();
        ext_val <= r;
        rd(DIR);
        chk("dir", rd_data, `GPB_RST_DIR);
        rd(LAT);
        chk("latch", rd_data, `GPB_RST_LATCH);
        rd(CTL2);
        chk("ctl2", rd_data, `GPB_RST_INTCTL2);
        rd(PINS);
        chk("pins analog", rd_data, f_pins(r, `GPB_ANALOG_ALL));
        do_reset(0);
        rd(ANA);
        chk("analog", rd_data, 32'h0);
        rd(PINS);
        chk("pins digital", rd_data, f_pins(r, 5'h00));
        rd(5'h18);
        chk("unmapped resp", rd_resp, `GPB_RESP_SLVERR);
        chk("unmapped data", rd_data, 32'h0);
        wr(5'h1c, 32'h0);
        chk("bresp unmapped", wr_resp, `GPB_RESP_SLVERR);
        d = rnd();
        wr(LAT, {24'h0, d});
        chk("bresp", wr_resp, `GPB_RESP_OKAY);
        wr(DIR, 32'h0);
        repeat (2) @(posedge clk_i);
        chk("drive", {pin_oe_n_o, pin_out_o}, {8'h00, d});
        rd(LAT);
        chk("latch rd", rd_data, {24'h0, d});
        rd(PINS);
        chk("pins out", rd_data, {24'h0, d});
        for (int i = 0; i < 4; i++) begin
            d = rnd();
            k = {i[0], 7'h0};
            wr(CTL2, {24'h0, k});
            wr(DIR, {24'h0, d});
            repeat (2) @(posedge clk_i);
            chk("pullups", pullup_on_o, f_pull(d, k));
        end
        // the port is read ahead of the first and last clears, by move form once, and once to check mixed levels, never polled
        wr(DIR, 32'hff);
        repeat (4) @(posedge clk_i);
        rd(PINS);
        wr(IMAIN, 32'h0);
        wait_flag(0);
        d = rnd();
        ext_val <= r ^ (8'h10 << d[1:0]);
        wait_flag(1);
        wr(IMAIN, 32'h0);
        repeat (3) @(posedge clk_i);
        chk("flag held", port_change_flag_o, 1'b1);
        move_read_i <= 1;
        rd(PINS);
        move_read_i <= 0;
        wr(IMAIN, 32'h0);
        repeat (3) @(posedge clk_i);
        chk("flag move", port_change_flag_o, 1'b1);
        rd(PINS);
        wr(IMAIN, 32'h0);
        wait_flag(0);
        ext_val <= ext_val ^ 8'h0f;
        repeat (6) @(posedge clk_i);
        chk("flag low", port_change_flag_o, 1'b0);
        k = ext_val;
        wr(LAT, {24'h0, ~k});
        wr(DIR, 32'h0f);
        repeat (6) @(posedge clk_i);
        chk("flag out", port_change_flag_o, 1'b0);
        rd(PINS);
        chk("pins mixed", rd_data, {24'h0, ~k[7:4], k[3:0]});
        wr(DIR, 32'hf7);
        capcomp2_pin_map_cfg_i <= 0;
        low_voltage_prog_cfg_i <= 1;
        for (int i = 0; i < 12; i++) begin
            k = rnd();
            ext_val <= rnd();
            {prog_data_out_i, prog_data_oe_i, prog_active_i, pwm_fault_en_i, capture_compare_2_out_i} <= k[4:0];
            repeat (3) @(posedge clk_i);
            chk("ext irq", ext_irq_o, ext_val[2:0]);
            chk("fault", pwm_fault_input_o, ext_val[0] & k[1]);
            chk("pin3 compare", pin_in_i[3], k[0]);
            chk("serial data", prog_serial_data_o, k[2] & (k[3] ? k[4] : ext_val[7]));
        end
        wr(DIR, 32'hff);
        repeat (3) @(posedge clk_i);
        chk("capture", capture_compare_2_capture_o, ext_val[3]);
        complete_run();
    end
endmodule // tb_gpb_port
`default_nettype wire
